/* File: bmcr_pkg.sv */
// Package: offsets, bit positions, defaults and timing for the basic control register
`default_nettype none
package bmcr_pkg;
  localparam logic [4:0]  REG_ADDR_BMCR     = 5'h00;
  localparam logic [4:0]  REG_ADDR_STATUS   = 5'h01;
  localparam int          BIT_SW_RESET      = 15;
  localparam int          BIT_LOOPBACK      = 14;
  localparam int          BIT_RATE          = 13;
  localparam int          BIT_AN_ENABLE     = 12;
  localparam int          BIT_LOW_POWER     = 11;
  localparam int          BIT_ISOLATE       = 10;
  localparam int          BIT_AN_RESTART    = 9;
  localparam int          BIT_DUPLEX        = 8;
  localparam int          BIT_COL_TEST      = 7;
  // Defaults with the isolate bit left out; it comes from the latched address
  localparam logic [15:0] BMCR_DEFAULT      = 16'h3000;
  localparam logic [15:0] BMCR_WRITE_MASK   = 16'hff80;
  localparam logic [4:0]  PHY_ADDR_ISOLATE  = 5'h00;
  // Cycles the software reset holds the block busy
  localparam int          SW_RESET_CYCLES   = 16;
  // Bit time at 100 Mbps is 10 ns; clock period 50 ns
  localparam int          CLK_PERIOD_NS     = 50;
  localparam int          BIT_TIME_NS       = 10;
  localparam int          LOOP_LIMIT_BITS   = 512;
  localparam int          COL_OFF_BITS      = 4;
  localparam int          LOOP_LIMIT_CYCLES = (LOOP_LIMIT_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;
  localparam int          COL_OFF_CYCLES    = ((COL_OFF_BITS * BIT_TIME_NS) / CLK_PERIOD_NS) < 1 ? 1 :
                                              ((COL_OFF_BITS * BIT_TIME_NS) / CLK_PERIOD_NS);
  localparam logic [3:0]  RST_CNT_INIT      = 4'(SW_RESET_CYCLES - 1);
endpackage
`default_nettype wire

/* File: basic_mode_control.sv */
// Basic control register of the PHY with its effects on the MAC-side data path
//
// How it works
// - One 16-bit register at management address zero, MAC-side setup irrelevant.
// - Writing bit 15 starts software reset: registers default, state machines idle.
// - During software reset bit 15 reads one, writes ignored, then self-clears.
// - Loopback bit 14 disables line transmit, receive, collision; loops transmit to receive.
// - Loopback transmit-enable to receive-valid delay stays below 512 bit times.
// - Collision test bit 7 drives collision from transmit enable, even in loopback; defaults zero.
// - With negotiation off, bit 13 picks 10 or 100 Mbps; default one.
// - Negotiation enable bit 12 (default one) takes speed and duplex from result.
// - With negotiation off, bit 8 picks half or full duplex; default zero.
// - Low-power bit 11 stops functions, drives MAC outputs low, tristates line.
// - Entering low power keeps registers but resets latching status bits.
// - Isolate bit 10 floats MAC outputs and ignores MAC inputs; management works.
// - Isolate defaults to one when latched PHY address is zero, else zero.
// - Restart bit 9 writes of one are ignored while negotiation is disabled.
// - With negotiation on, restart bit restarts it and clears once begun.
// - Restart acts only when hardware/software select pin is high.
// - Reserved bits 6..0 read zero; manager must write zeros there.
// - Any reset loads every bit with its default, including strap-derived ones.
// - Collision test raises collision within 512 bit times, drops three clocks (15 bit times) after MAC transmit enable falls.
// - Latching-high flag holds until reset, which clears it, or a status read or low-power entry, which reload current state.
`default_nettype none
module basic_mode_control
  import bmcr_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic [4:0]  phy_addr_i,
  input  wire logic        hardware_software_select_i,
  input  wire logic        mgmt_wr_i,
  input  wire logic        mgmt_rd_i,
  input  wire logic [4:0]  mgmt_reg_addr_i,
  input  wire logic [15:0] mgmt_wdata_i,
  output logic      [15:0] mgmt_rdata_o,
  input  wire logic        an_started_i,
  input  wire logic        an_speed_100_i,
  input  wire logic        an_full_duplex_i,
  input  wire logic        mac_tx_en_i,
  input  wire logic [3:0]  mac_txd_i,
  input  wire logic        mac_tx_er_i,
  input  wire logic        line_rx_dv_i,
  input  wire logic [3:0]  line_rxd_i,
  input  wire logic        line_collision_i,
  input  wire logic        monitored_event_i,
  output logic             mac_rx_dv_o,
  output logic      [3:0]  mac_rxd_o,
  output logic             mac_rx_er_o,
  output logic             mac_col_o,
  output logic             mac_out_oe_o,
  output logic             line_tx_en_o,
  output logic      [3:0]  line_txd_o,
  output logic             twisted_pair_tx_tristate_o,
  output logic             line_rx_enable_o,
  output logic             an_restart_o,
  output logic             speed_100_o,
  output logic             full_duplex_o,
  output logic             sm_idle_o,
  output logic             latching_high_flag_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [8:0] pin_s1_q, pin_s2_q;
  logic [4:0] addr_s;
  logic       hws_s;
  logic [3:0] txd_s;
  logic       txen_s, txer_s, evt_s;
  always_ff @(posedge clk_sys_i) begin
    pin_s1_q <= {evt_s_raw(), hardware_software_select_i, mac_tx_er_i, mac_tx_en_i, phy_addr_i};
    pin_s2_q <= pin_s1_q;
  end
  function automatic logic evt_s_raw();
    return monitored_event_i;
  endfunction
  assign addr_s = pin_s2_q[4:0];
  assign txen_s = pin_s2_q[5];
  assign txer_s = pin_s2_q[6];
  assign hws_s  = pin_s2_q[7];
  assign evt_s  = pin_s2_q[8];
  // Transmit data follows enable through the same two stages
  logic [3:0] txd_s1_q, txd_s2_q;
  always_ff @(posedge clk_sys_i) begin
    txd_s1_q <= mac_txd_i;
    txd_s2_q <= txd_s1_q;
  end
  assign txd_s = txd_s2_q;

  // ****************************************
  // Register state
  // ****************************************
  typedef enum logic [0:0] {ST_RUN, ST_SW_RESET} rst_state_e;
  rst_state_e  st_q, st_d;
  logic [3:0]  rst_cnt_q, rst_cnt_d;
  logic [15:0] ctl_q, ctl_d;
  logic        lh_q, lh_d;
  logic        lp_prev_q, lp_prev_d;
  logic        strap_iso;
  logic        wr_hit, rd_hit;

  assign strap_iso = (addr_s == PHY_ADDR_ISOLATE);
  assign wr_hit = mgmt_wr_i && (mgmt_reg_addr_i == REG_ADDR_BMCR) && (st_q == ST_RUN);
  assign rd_hit = mgmt_rd_i && (mgmt_reg_addr_i == REG_ADDR_BMCR);

  function automatic logic [15:0] defaults(input logic iso);
    logic [15:0] v;
    v = BMCR_DEFAULT;
    v[BIT_ISOLATE] = iso;
    return v;
  endfunction

  always_comb begin
    st_d      = st_q;
    rst_cnt_d = rst_cnt_q;
    ctl_d     = ctl_q;
    lh_d      = lh_q | evt_s;
    lp_prev_d = ctl_q[BIT_LOW_POWER];
    // An event in the entry cycle still sets the flag, so it is never lost
    if (ctl_q[BIT_LOW_POWER] && !lp_prev_q) begin
      lh_d = evt_s;
    end
    if (mgmt_rd_i && (mgmt_reg_addr_i == REG_ADDR_STATUS) && (st_q == ST_RUN)) begin
      lh_d = evt_s;
    end
    case (st_q)
      ST_RUN: begin
        if (ctl_q[BIT_AN_RESTART] && an_started_i) begin
          ctl_d[BIT_AN_RESTART] = 1'b0;
        end
        if (wr_hit) begin
          ctl_d = mgmt_wdata_i & BMCR_WRITE_MASK;
          if (!mgmt_wdata_i[BIT_AN_ENABLE] || !hws_s) begin
            ctl_d[BIT_AN_RESTART] = 1'b0;
          end
          if (mgmt_wdata_i[BIT_SW_RESET]) begin
            st_d      = ST_SW_RESET;
            rst_cnt_d = RST_CNT_INIT;
            ctl_d     = defaults(strap_iso);
            ctl_d[BIT_SW_RESET] = 1'b1;
            lh_d      = 1'b0;
          end
        end
      end
      ST_SW_RESET: begin
        ctl_d = defaults(strap_iso);
        ctl_d[BIT_SW_RESET] = 1'b1;
        lh_d  = 1'b0;
        if (rst_cnt_q == 4'h0) begin
          ctl_d[BIT_SW_RESET] = 1'b0;
          st_d = ST_RUN;
        end else begin
          rst_cnt_d = rst_cnt_q - 4'h1;
        end
      end
      default: st_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_q      <= ST_RUN;
      rst_cnt_q <= 4'h0;
      ctl_q     <= defaults(strap_iso);
      lh_q      <= 1'b0;
      lp_prev_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      rst_cnt_q <= rst_cnt_d;
      ctl_q     <= ctl_d;
      lh_q      <= lh_d;
      lp_prev_q <= lp_prev_d;
    end
  end

  // ****************************************
  // Read data, mode decode
  // ****************************************
  logic [15:0] rdata_d, rdata_q;
  always_comb begin
    rdata_d = rdata_q;
    if (rd_hit) begin
      rdata_d = ctl_q & BMCR_WRITE_MASK;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) rdata_q <= 16'h0000;
    else        rdata_q <= rdata_d;
  end
  assign mgmt_rdata_o = rdata_q;

  logic loop, lowp, iso, coltest;
  assign loop    = ctl_q[BIT_LOOPBACK];
  assign lowp    = ctl_q[BIT_LOW_POWER];
  assign iso     = ctl_q[BIT_ISOLATE];
  assign coltest = ctl_q[BIT_COL_TEST];
  assign speed_100_o   = ctl_q[BIT_AN_ENABLE] ? an_speed_100_i   : ctl_q[BIT_RATE];
  assign full_duplex_o = ctl_q[BIT_AN_ENABLE] ? an_full_duplex_i : ctl_q[BIT_DUPLEX];
  assign an_restart_o  = ctl_q[BIT_AN_RESTART];
  assign sm_idle_o     = (st_q == ST_SW_RESET);
  assign latching_high_flag_o = lh_q;

  // ****************************************
  // Data path
  // ****************************************
  logic       tx_en_g, tx_er_g;
  logic [3:0] txd_g;
  // Isolated or powered down, MAC inputs are treated as idle
  assign tx_en_g = txen_s & ~iso & ~lowp;
  assign tx_er_g = txer_s & ~iso & ~lowp;
  assign txd_g   = (iso | lowp) ? 4'h0 : txd_s;

  logic       rx_dv_q, rx_er_q, col_q, ltx_q;
  logic [3:0] rxd_q, ltxd_q;
  logic       rx_dv_d, rx_er_d, col_d, ltx_d;
  logic [3:0] rxd_d, ltxd_d;
  always_comb begin
    // Loopback adds one cycle, far under the 512 bit-time budget
    rx_dv_d = loop ? tx_en_g : line_rx_dv_i;
    rxd_d   = loop ? txd_g   : line_rxd_i;
    rx_er_d = loop ? tx_er_g : 1'b0;
    col_d   = coltest ? tx_en_g : (loop ? 1'b0 : line_collision_i);
    ltx_d   = loop ? 1'b0 : tx_en_g;
    ltxd_d  = loop ? 4'h0 : txd_g;
    if (lowp) begin
      {rx_dv_d, rxd_d, rx_er_d, col_d, ltx_d, ltxd_d} = '0;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      {rx_dv_q, rxd_q, rx_er_q, col_q, ltx_q, ltxd_q} <= '0;
    end else begin
      {rx_dv_q, rxd_q, rx_er_q, col_q, ltx_q, ltxd_q} <= {rx_dv_d, rxd_d, rx_er_d, col_d, ltx_d, ltxd_d};
    end
  end
  assign mac_rx_dv_o  = rx_dv_q;
  assign mac_rxd_o    = rxd_q;
  assign mac_rx_er_o  = rx_er_q;
  assign mac_col_o    = col_q;
  assign mac_out_oe_o = ~iso;
  assign line_tx_en_o = ltx_q;
  assign line_txd_o   = ltxd_q;
  assign twisted_pair_tx_tristate_o = lowp;
  assign line_rx_enable_o = ~loop & ~lowp;

  // ****************************************
  // Checks
  // ****************************************
  chk_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    mgmt_rdata_o[6:0] == 7'h00) else $error("reserved bits nonzero");
  chk_reset_busy: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (st_q == ST_SW_RESET) |-> ctl_q[BIT_SW_RESET]) else $error("reset bit low while busy");
  chk_reset_ends: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $rose(st_q == ST_SW_RESET) |-> ##[1:20] !ctl_q[BIT_SW_RESET]) else $error("reset never ends");
  chk_loop_delay: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (loop && !lowp && !iso && $rose(txen_s)) |-> ##[1:2] mac_rx_dv_o) else $error("loopback late");
  chk_col_test: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (coltest && !lowp && !iso && $fell(txen_s)) |-> ##1 !mac_col_o) else $error("collision stuck");
  chk_restart_off: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !ctl_q[BIT_AN_ENABLE] |-> ##1 (!ctl_q[BIT_AN_ENABLE] |-> !ctl_q[BIT_AN_RESTART]))
    else $error("restart while disabled");
  chk_lowp_quiet: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (lowp && $past(lowp)) |-> (!mac_rx_dv_o && !line_tx_en_o && twisted_pair_tx_tristate_o))
    else $error("low power active");
  chk_speed_sel: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !ctl_q[BIT_AN_ENABLE] |-> (speed_100_o == ctl_q[BIT_RATE] && full_duplex_o == ctl_q[BIT_DUPLEX]))
    else $error("forced mode wrong");
  chk_loop_line: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (loop && $past(loop)) |-> !line_tx_en_o) else $error("line driven in loopback");

  // ****************************************
  // Checks on reset defaults, status and gating
  // ****************************************
  // The isolate default follows the address seen at the last reset edge
  chk_strap_default: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $fell(srst_i) |-> (ctl_q == defaults($past(strap_iso))))
    else $error("defaults wrong after reset");
  chk_lowp_entry: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ($rose(lowp) && !mgmt_wr_i) |=> (latching_high_flag_o == $past(evt_s)))
    else $error("latching flag kept on low-power entry");
  chk_restart_clear: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (ctl_q[BIT_AN_RESTART] && an_started_i && !mgmt_wr_i) |=> !ctl_q[BIT_AN_RESTART])
    else $error("restart bit not cleared");
  chk_hws_gate: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (wr_hit && !hws_s) |=> !ctl_q[BIT_AN_RESTART])
    else $error("restart taken in hardware mode");
  // A status read reloads the flag with what the event input shows in that cycle
  chk_lh_read: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (mgmt_rd_i && (mgmt_reg_addr_i == REG_ADDR_STATUS) && (st_q == ST_RUN) && !mgmt_wr_i)
    |=> (latching_high_flag_o == $past(evt_s)))
    else $error("latching flag not reloaded");
  chk_iso_quiet: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (iso && $past(iso)) |-> (!line_tx_en_o && !mac_out_oe_o))
    else $error("isolated data path active");
  chk_col_rise: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (coltest && !lowp && !iso && $rose(txen_s)) |=> mac_col_o)
    else $error("collision test missed");
  chk_rdata_holds: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !rd_hit |=> $stable(mgmt_rdata_o))
    else $error("read data changed without a read");

endmodule // basic_mode_control
`default_nettype wire

/* File: station_manager_model.sv */
// Station manager model driving the management access strobes of the control register
`default_nettype none
module station_manager_model (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] mgmt_rdata_i,
  output logic             mgmt_wr_o,
  output logic             mgmt_rd_o,
  output logic      [4:0]  mgmt_reg_addr_o,
  output logic      [15:0] mgmt_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    mgmt_wr_o       = 1'b0;
    mgmt_rd_o       = 1'b0;
    mgmt_reg_addr_o = 5'h1f;
    mgmt_wdata_o    = 16'hffff;
  end
  // One-cycle strobe marks the end of a write frame
  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    mgmt_wr_o       <= 1'b1;
    mgmt_reg_addr_o <= a;
    mgmt_wdata_o    <= d & 16'hff80;
    @(posedge clk_sys_i);
    mgmt_wr_o       <= 1'b0;
    // Released lines show the inverse, so stale data never passes for valid
    mgmt_reg_addr_o <= ~a;
    mgmt_wdata_o    <= ~d;
  endtask
  task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    mgmt_rd_o       <= 1'b1;
    mgmt_reg_addr_o <= a;
    @(posedge clk_sys_i);
    mgmt_rd_o       <= 1'b0;
    mgmt_reg_addr_o <= ~a;
    @(posedge clk_sys_i);
    d = mgmt_rdata_i;
  endtask
endmodule // station_manager_model
`default_nettype wire

/* File: test_basic_mode_control.sv */
// Self-checking testbench for the basic control register
`default_nettype none
module test_basic_mode_control;
  import bmcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 0, srst_i = 1, hws = 1, an_started = 0, an_spd = 1, an_fd = 1;
  logic tx_en = 0, tx_er = 0, l_dv = 0, l_col = 0, mon_ev = 0;
  logic [4:0] phy_addr = 5'h00, addr;
  logic [3:0] txd = 4'h5, l_rxd = 4'ha, rxd, ltxd;
  logic [15:0] wdata, rdata, d;
  logic wr, rd, rx_dv, rx_er, col, oe, ltx_en, tri_o, lrx_en, restart, spd, fd, idle, lh;
  int num_errors = 0, total_checks = 0, cyc = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  basic_mode_control i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .phy_addr_i(phy_addr),
    .hardware_software_select_i(hws), .mgmt_wr_i(wr), .mgmt_rd_i(rd), .mgmt_reg_addr_i(addr),
    .mgmt_wdata_i(wdata), .mgmt_rdata_o(rdata), .an_started_i(an_started), .an_speed_100_i(an_spd),
    .an_full_duplex_i(an_fd), .mac_tx_en_i(tx_en), .mac_txd_i(txd), .mac_tx_er_i(tx_er),
    .line_rx_dv_i(l_dv), .line_rxd_i(l_rxd), .line_collision_i(l_col), .monitored_event_i(mon_ev),
    .mac_rx_dv_o(rx_dv), .mac_rxd_o(rxd), .mac_rx_er_o(rx_er), .mac_col_o(col), .mac_out_oe_o(oe),
    .line_tx_en_o(ltx_en), .line_txd_o(ltxd), .twisted_pair_tx_tristate_o(tri_o),
    .line_rx_enable_o(lrx_en), .an_restart_o(restart), .speed_100_o(spd), .full_duplex_o(fd),
    .sm_idle_o(idle), .latching_high_flag_o(lh));
  station_manager_model i_sta (.clk_sys_i(clk_sys_i), .mgmt_rdata_i(rdata), .mgmt_wr_o(wr),
    .mgmt_rd_o(rd), .mgmt_reg_addr_o(addr), .mgmt_wdata_o(wdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic t_defaults;
    i_sta.read_reg(5'h00, d);
    check(d, 16'h3400);
    check(oe, 1'b0);
    $display("defaults done");
  endtask
  task automatic t_rate;
    i_sta.write_reg(5'h00, 16'h0100);
    wait_cyc(2);
    check({spd, fd}, 2'b01);
    i_sta.write_reg(5'h00, 16'h2000);
    wait_cyc(2);
    check({spd, fd}, 2'b10);
    i_sta.write_reg(5'h00, 16'h107f);
    wait_cyc(2);
    check({spd, fd}, 2'b11);
    i_sta.write_reg(5'h02, 16'h4000);
    i_sta.read_reg(5'h00, d);
    check(d, 16'h1000);
    check(lrx_en, 1'b1);
    $display("rate and duplex done");
  endtask
  task automatic t_restart;
    i_sta.write_reg(5'h00, 16'h0200);
    i_sta.read_reg(5'h00, d);
    check(d, 16'h0000);
    i_sta.write_reg(5'h00, 16'h1200);
    wait_cyc(2);
    check(restart, 1'b1);
    an_started <= 1'b1;
    wait_cyc(4);
    check(restart, 1'b0);
    an_started <= 1'b0;
    hws <= 1'b0;
    wait_cyc(3);
    i_sta.write_reg(5'h00, 16'h1200);
    wait_cyc(2);
    check(restart, 1'b0);
    hws <= 1'b1;
    $display("restart done");
  endtask
  task automatic t_loop;
    int n;
    i_sta.write_reg(5'h00, 16'h4000);
    wait_cyc(2);
    check(lrx_en, 1'b0);
    tx_en <= 1'b1;
    for (n = 0; n < LOOP_LIMIT_CYCLES && rx_dv !== 1'b1; n++) wait_cyc(1);
    check(rx_dv, 1'b1);
    check({col, rxd}, 5'h05);
    tx_en <= 1'b0;
    i_sta.write_reg(5'h00, 16'h4080);
    tx_en <= 1'b1;
    wait_cyc(5);
    check(col, 1'b1);
    tx_en <= 1'b0;
    wait_cyc(5);
    check(col, 1'b0);
    $display("loopback done");
  endtask
  task automatic t_lowpower;
    i_sta.write_reg(5'h00, 16'h0000);
    mon_ev <= 1'b1;
    tx_en <= 1'b1;
    l_dv <= 1'b1;
    wait_cyc(4);
    check({ltx_en, ltxd, rx_dv, rxd, rx_er}, 11'h574);
    mon_ev <= 1'b0;
    wait_cyc(4);
    check(lh, 1'b1);
    i_sta.read_reg(5'h01, d);
    wait_cyc(3);
    check(lh, 1'b0);
    mon_ev <= 1'b1;
    wait_cyc(4);
    mon_ev <= 1'b0;
    i_sta.write_reg(5'h00, 16'h0800);
    wait_cyc(3);
    check({tri_o, lh, rx_dv, ltx_en}, 4'h8);
    i_sta.read_reg(5'h00, d);
    check(d, 16'h0800);
    tx_en <= 1'b0;
    l_dv <= 1'b0;
    $display("low power done");
  endtask
  task automatic t_swreset;
    phy_addr <= 5'h01;
    wait_cyc(3);
    i_sta.write_reg(5'h00, 16'h8000);
    i_sta.read_reg(5'h00, d);
    check({d[15], idle}, 2'b11);
    i_sta.write_reg(5'h00, 16'h0100);
    wait_cyc(SW_RESET_CYCLES + 4);
    i_sta.read_reg(5'h00, d);
    check(d, 16'h3000);
    check(oe, 1'b1);
    tx_en <= 1'b1;
    phy_addr <= 5'h00;
    srst_i <= 1'b1;
    wait_cyc(4);
    srst_i <= 1'b0;
    i_sta.read_reg(5'h00, d);
    check(d, 16'h3400);
    wait_cyc(3);
    check({oe, ltx_en}, 2'b00);
    tx_en <= 1'b0;
    $display("software reset done");
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Ceiling well above the fewer than 200 cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    wait_cyc(4);
    srst_i <= 1'b0;
    t_defaults();
    t_rate();
    t_restart();
    t_loop();
    t_lowpower();
    t_swreset();
    end_of_test();
  end
endmodule // test_basic_mode_control
`default_nettype wire
